// File: scw_control_word.sv
// Control word one: register bank, staging buffer and derived control outputs.
module scw_control_word
	import scw_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic        wr_en_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic        rd_en_i,
	output logic      [31:0] rd_data_o,
	input  wire logic        update_i,
	input  wire logic [2:0]  profile_select_pins_i,
	output logic             phase_acc_clear_o,
	output logic             ramp_acc_clear_o,
	output logic             amplitude_keying_enable_o,
	output logic             amplitude_keying_auto_o,
	output logic             digital_core_powerdown_o,
	output logic             converter_powerdown_o,
	output logic             reference_clock_input_powerdown_o,
	output logic             external_powerdown_fast_o,
	output logic             serial_three_wire_o,
	output logic             serial_lsb_first_o
);
	import scw_pkg::*;

	// ------------------------------------------------------------------
	// Commit event
	// ------------------------------------------------------------------
	scw_commit_if cm ();

	scw_commit_sync u_sync (
		.clk_sys_i             (clk_sys_i),
		.rst_i                 (rst_i),
		.update_i              (update_i),
		.profile_select_pins_i (profile_select_pins_i),
		.cm                    (cm)
	);

	function automatic logic hit_word(input logic [7:0] a);
		return a == ADDR_CONTROL_WORD_ONE;
	endfunction : hit_word

	// Autoclear bits give a pulse only in the cycle of a commit.
	function automatic logic commit_pulse(input logic commit, input logic [31:0] word,
		input int idx);
		return commit & word[idx];
	endfunction : commit_pulse

	// Bit 16 of the reset value lies outside this block and is masked off.
	localparam logic [31:0] RESET_WORD = CW1_RESET & CW1_IMPL_MASK;

	// ------------------------------------------------------------------
	// Staging buffer
	// ------------------------------------------------------------------
	// Written words wait here until a commit moves them to the active word; the immediate bits reach it at once.
	logic [31:0] staged;
	logic [31:0] next_staged;

	always_comb begin
		next_staged = staged;
		if (wr_en_i && hit_word(addr_i)) begin
			next_staged = wr_data_i & CW1_IMPL_MASK;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			staged <= RESET_WORD;
		end else begin
			staged <= next_staged;
		end
	end

	// ------------------------------------------------------------------
	// Active word
	// ------------------------------------------------------------------
	logic [31:0] active;
	logic [31:0] next_active;

	always_comb begin
		// Immediate bits follow the staging buffer every cycle.
		next_active = (active & ~CW1_IMMEDIATE_MASK)
			| (next_staged & CW1_IMMEDIATE_MASK);
		// A write and a commit in the same cycle commit the new word.
		if (cm.commit) begin
			next_active = next_staged;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			active <= RESET_WORD;
		end else begin
			active <= next_active;
		end
	end

	// ------------------------------------------------------------------
	// Control output registers
	// ------------------------------------------------------------------
	// Outputs are registered from the next active word, so they change at
	// the same edge as the word itself and never glitch downstream.
	scw_pd_mode_t pd_mode;
	logic         phase_clear;
	logic         ramp_clear;
	logic         key_enable;
	logic         key_auto;
	logic         digital_pd;
	logic         conv_pd;
	logic         ref_pd;
	logic         ext_fast;
	logic         three_wire;
	logic         lsb_first;

	logic         next_phase_clear;
	logic         next_ramp_clear;
	logic         next_key_enable;
	logic         next_key_auto;
	logic         next_digital_pd;
	logic         next_conv_pd;
	logic         next_ref_pd;
	logic         next_ext_fast;
	logic         next_three_wire;
	logic         next_lsb_first;

	always_comb begin
		pd_mode          = next_active[BIT_EXT_PD_FAST] ? PD_PIN_FAST : PD_PIN_FULL;
		next_phase_clear = next_active[BIT_CLR_PHASE]
			| commit_pulse(cm.commit, next_staged, BIT_AUTOCLR_PHASE);
		next_ramp_clear  = next_active[BIT_CLR_RAMP]
			| commit_pulse(cm.commit, next_staged, BIT_AUTOCLR_RAMP);
		next_key_enable  = next_active[BIT_KEY_EN];
		next_key_auto    = next_active[BIT_KEY_EN] & next_active[BIT_KEY_AUTO];
		next_digital_pd  = next_active[BIT_DIG_PD];
		next_conv_pd     = next_active[BIT_CONV_PD];
		next_ref_pd      = next_active[BIT_REF_PD];
		next_ext_fast    = (pd_mode == PD_PIN_FAST);
		next_three_wire  = next_active[BIT_SDIO_IN_ONLY];
		next_lsb_first   = next_active[BIT_LSB_FIRST];
	end

	// Reset values follow the reset word, so the pin mode starts at fast recovery.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			phase_clear <= RESET_WORD[BIT_CLR_PHASE];
			ramp_clear  <= RESET_WORD[BIT_CLR_RAMP];
			key_enable  <= RESET_WORD[BIT_KEY_EN];
			key_auto    <= RESET_WORD[BIT_KEY_EN] & RESET_WORD[BIT_KEY_AUTO];
			digital_pd  <= RESET_WORD[BIT_DIG_PD];
			conv_pd     <= RESET_WORD[BIT_CONV_PD];
			ref_pd      <= RESET_WORD[BIT_REF_PD];
			ext_fast    <= RESET_WORD[BIT_EXT_PD_FAST];
			three_wire  <= RESET_WORD[BIT_SDIO_IN_ONLY];
			lsb_first   <= RESET_WORD[BIT_LSB_FIRST];
		end else begin
			phase_clear <= next_phase_clear;
			ramp_clear  <= next_ramp_clear;
			key_enable  <= next_key_enable;
			key_auto    <= next_key_auto;
			digital_pd  <= next_digital_pd;
			conv_pd     <= next_conv_pd;
			ref_pd      <= next_ref_pd;
			ext_fast    <= next_ext_fast;
			three_wire  <= next_three_wire;
			lsb_first   <= next_lsb_first;
		end
	end

	// ------------------------------------------------------------------
	// Readback
	// ------------------------------------------------------------------
	logic [31:0] rd_data;
	logic [31:0] next_rd_data;

	always_comb begin
		next_rd_data = rd_data;
		if (rd_en_i) begin
			// Readback shows the staged word, not the committed one.
			next_rd_data = hit_word(addr_i) ? staged : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rd_data_o                         = rd_data;
	assign phase_acc_clear_o                 = phase_clear;
	assign ramp_acc_clear_o                  = ramp_clear;
	assign amplitude_keying_enable_o         = key_enable;
	assign amplitude_keying_auto_o           = key_auto;
	assign digital_core_powerdown_o          = digital_pd;
	assign converter_powerdown_o             = conv_pd;
	assign reference_clock_input_powerdown_o = ref_pd;
	assign external_powerdown_fast_o         = ext_fast;
	assign serial_three_wire_o               = three_wire;
	assign serial_lsb_first_o                = lsb_first;
endmodule : scw_control_word

// File: scw_pkg.sv
// Package with the offsets, field positions and reset values of control word one.
package scw_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0]  ADDR_CONTROL_WORD_ONE = 8'h00;
	localparam logic [31:0] CW1_RESET             = 32'h0001_0008;
	// Bits that this block implements; all others read as zero.
	localparam logic [31:0] CW1_IMPL_MASK         = 32'h0000_7BEB;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int BIT_LSB_FIRST      = 0;
	localparam int BIT_SDIO_IN_ONLY   = 1;
	localparam int BIT_EXT_PD_FAST    = 3;
	localparam int BIT_REF_PD         = 5;
	localparam int BIT_CONV_PD        = 6;
	localparam int BIT_DIG_PD         = 7;
	localparam int BIT_KEY_EN         = 8;
	localparam int BIT_KEY_AUTO       = 9;
	localparam int BIT_CLR_PHASE      = 11;
	localparam int BIT_CLR_RAMP       = 12;
	localparam int BIT_AUTOCLR_PHASE  = 13;
	localparam int BIT_AUTOCLR_RAMP   = 14;

	// Bits that act at once, without waiting for the update strobe.
	localparam logic [31:0] CW1_IMMEDIATE_MASK = 32'h0000_00A0;

	typedef enum logic [1:0] {
		PD_PIN_FULL = 2'b01,
		PD_PIN_FAST = 2'b10
	} scw_pd_mode_t;

endpackage : scw_pkg

// File: scw_commit_if.sv
// Interface carrying the commit event from the sync stage to the register bank.
interface scw_commit_if;
	logic commit;
	modport src (output commit);
	modport dst (input commit);
endinterface : scw_commit_if

// File: scw_commit_sync.sv
// Commit event detector: update strobe or profile change, on the sync clock edge.
module scw_commit_sync
	import scw_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       update_i,
	input  wire logic [2:0] profile_select_pins_i,
	scw_commit_if.src       cm
);
	logic [2:0] prof_q;
	logic [2:0] next_prof_q;

	always_comb begin
		next_prof_q = profile_select_pins_i;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			prof_q <= 3'h0;
		end else begin
			prof_q <= next_prof_q;
		end
	end

	assign cm.commit = update_i | (prof_q != profile_select_pins_i);
endmodule : scw_commit_sync

// File: scw_control_word_props.sv
// Checker for control word one: staging, commit timing, immediate bits and readback.
module scw_chk
	import scw_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic [7:0]  addr_i,
	input wire logic        wr_en_i,
	input wire logic [31:0] wr_data_i,
	input wire logic        rd_en_i,
	input wire logic [31:0] rd_data_o,
	input wire logic        update_i,
	input wire logic [2:0]  profile_select_pins_i,
	input wire logic        phase_acc_clear_o,
	input wire logic        ramp_acc_clear_o,
	input wire logic        amplitude_keying_enable_o,
	input wire logic        amplitude_keying_auto_o,
	input wire logic        digital_core_powerdown_o,
	input wire logic        converter_powerdown_o,
	input wire logic        reference_clock_input_powerdown_o
);
	// ------------------------------------------------------------------
	// Shadow of the staged word and of the commit event
	// ------------------------------------------------------------------
	logic [31:0] stg, next_stg;
	logic [2:0]  prev_ps;
	logic        wr, cm;
	assign wr = wr_en_i && addr_i == 8'h00;
	assign cm = update_i || profile_select_pins_i != prev_ps;
	always_comb next_stg = wr ? wr_data_i & CW1_IMPL_MASK : stg;
	always_ff @(posedge clk_sys_i or posedge rst_i)
		if (rst_i) {stg, prev_ps} <= {CW1_RESET & CW1_IMPL_MASK, 3'h0};
		else {stg, prev_ps} <= {next_stg, profile_select_pins_i};
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_dpd; wr |=> digital_core_powerdown_o == $past(wr_data_i[7]); endproperty
	a_dpd: assert property (p_dpd) else $error("digital power-down not immediate");
	property p_rpd; wr |=> reference_clock_input_powerdown_o == $past(wr_data_i[5]); endproperty
	a_rpd: assert property (p_rpd) else $error("reference power-down not immediate");
	property p_conv; cm |=> converter_powerdown_o == $past(next_stg[6]); endproperty
	a_conv: assert property (p_conv) else $error("converter power-down not committed");
	property p_hold; !cm |=> $stable(converter_powerdown_o); endproperty
	a_hold: assert property (p_hold) else $error("staged bit acted without commit");
	property p_phs; cm && (next_stg[11] || next_stg[13]) |=> phase_acc_clear_o; endproperty
	a_phs: assert property (p_phs) else $error("phase clear missing");
	property p_nph; !cm && !phase_acc_clear_o |=> !phase_acc_clear_o; endproperty
	a_nph: assert property (p_nph) else $error("phase clear without commit");
	property p_ron; cm && (next_stg[12] || next_stg[14]) |=> ramp_acc_clear_o; endproperty
	a_ron: assert property (p_ron) else $error("ramp clear missing");
	property p_roff;
		cm && next_stg[14] && !next_stg[12] ##1 !cm |=> !ramp_acc_clear_o;
	endproperty
	a_roff: assert property (p_roff) else $error("ramp autoclear longer than one cycle");
	property p_key; amplitude_keying_auto_o |-> amplitude_keying_enable_o; endproperty
	a_key: assert property (p_key) else $error("auto keying without enable");
	property p_rd;
		rd_en_i && !wr_en_i |=> rd_data_o == ($past(addr_i) == 8'h00 ? $past(stg) : 32'h0000_0000);
	endproperty
	a_rd: assert property (p_rd) else $error("readback wrong");
	c_acl: cover property (cm && next_stg[13]);
	c_bad: cover property (rd_en_i && addr_i != 8'h00);
	c_dpd: cover property (wr && wr_data_i[7]);
endmodule : scw_chk
bind scw_control_word scw_chk chk (.*);

// File: tb_top.sv
// Testbench for control word one: register access, commit and readback.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys_i = 0, rst_i = 1, wr_en_i = 0, rd_en_i = 0, update_i = 0;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wr_data_i = 32'h0000_0000, rd_data_o;
	logic [2:0]  ps = 3'h0;
	logic        ph, rp, ke, ka, dp, cp, rf, ef, tw, lf;
	int          fail_count = 0, comparisons = 0, cycles = 0;
	scw_control_word uut (.clk_sys_i, .rst_i, .addr_i, .wr_en_i, .wr_data_i, .rd_en_i,
		.rd_data_o, .update_i, .profile_select_pins_i(ps), .phase_acc_clear_o(ph),
		.ramp_acc_clear_o(rp), .amplitude_keying_enable_o(ke), .amplitude_keying_auto_o(ka),
		.digital_core_powerdown_o(dp), .converter_powerdown_o(cp),
		.reference_clock_input_powerdown_o(rf), .external_powerdown_fast_o(ef),
		.serial_three_wire_o(tw), .serial_lsb_first_o(lf));
	wire [9:0] outs = {ph, rp, ke, ka, dp, cp, rf, ef, tw, lf};
	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_sys_i) {addr_i, wr_data_i, wr_en_i} = {a, d, 1'b1};
		@(negedge clk_sys_i) wr_en_i = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk_sys_i) {addr_i, rd_en_i} = {a, 1'b1};
		@(negedge clk_sys_i) rd_en_i = 0;
		chk(rd_data_o, e);
	endtask : rd
	task automatic up;
		@(negedge clk_sys_i) update_i = 1;
		@(negedge clk_sys_i) update_i = 0;
	endtask : up
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	initial forever #50 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (++cycles > 500) begin
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (3) @(negedge clk_sys_i);
		rst_i = 0;
		chk(outs, 10'h004);
		rd(8'h00, 32'h0000_0008);
		wr(8'h00, 32'hFFFF_FFFF);
		chk(outs, 10'h02C);
		rd(8'h00, 32'h0000_7BEB);
		wr(8'h01, 32'h0000_0000);
		rd(8'h01, 32'h0000_0000);
		up();
		chk(outs, 10'h3FF);
		wr(8'h00, 32'h0000_2000);
		up();
		chk(outs, 10'h200);
		@(negedge clk_sys_i) chk(outs, 10'h000);
		@(negedge clk_sys_i) ps = 3'h5;
		@(negedge clk_sys_i) chk(outs, 10'h200);
		wr(8'h00, 32'h0000_4A00);
		chk(outs, 10'h000);
		up();
		chk(outs, 10'h300);
		@(negedge clk_sys_i) chk(outs, 10'h200);
		wr(8'h00, 32'h0000_0103);
		up();
		chk(outs, 10'h083);
		// A reset in mid-run brings back the reset word; the nonzero profile
		// pins then cause one commit of that same word.
		@(negedge clk_sys_i) rst_i = 1;
		@(negedge clk_sys_i) chk(outs, 10'h004);
		rst_i = 0;
		rd(8'h00, 32'h0000_0008);
		@(negedge clk_sys_i) chk(outs, 10'h004);
		stop_test();
	end
endmodule : tb_top
